// ==== hw/fan_curve_pkg.sv ====
// Purpose: Shared constants and types for the fan PWM temperature-curve controller.
// Assumes: 250 MHz system clock, 3.2 MHz PWM reference derived from it.
// Notes: Periods are counted in reference ticks, not system cycles.
package fan_curve_pkg;
   // Register offsets
   localparam logic [7:0] FAN_CFG_ADDR = 8'h20;
   localparam logic [7:0] LOW_TEMP_DUTY_ADDR = 8'h21;
   localparam logic [7:0] LOCAL_CURVE_ADDR = 8'h24;
   localparam logic [7:0] REMOTE_CURVE_ADDR = 8'h25;
   // Reset values
   localparam logic [7:0] FAN_CFG_RST = 8'h1d;
   localparam logic [7:0] LOW_TEMP_DUTY_RST = 8'h55;
   localparam logic [7:0] LOCAL_CURVE_RST = 8'h41;
   localparam logic [7:0] REMOTE_CURVE_RST = 8'h61;
   localparam logic [7:0] FAN_CFG_WMASK = 8'hbf;
   // Reference clock: phase accumulator adds REF_KHZ, wraps at SYS_KHZ
   localparam int SYS_CLK_MHZ = 250;
   localparam int REF_CLK_KHZ = 3200;
   localparam int REF_HZ = REF_CLK_KHZ * 1000;
   localparam logic [17:0] ACC_STEP = 18'(REF_CLK_KHZ);
   localparam logic [17:0] ACC_MOD = 18'(SYS_CLK_MHZ * 1000);
   // Output frequencies per code
   localparam int LOW_FREQ_HZ [8] = '{10, 15, 23, 30, 38, 47, 62, 94};
   localparam int HIGH_FREQ_HZ [8] = '{1000, 10000, 20000, 25000, 30000, 40000, 40000, 40000};
   localparam logic [18:0] LOW_PERIOD_DEF [8] = '{
      19'(REF_HZ / 10), 19'(REF_HZ / 15), 19'(REF_HZ / 23), 19'(REF_HZ / 30),
      19'(REF_HZ / 38), 19'(REF_HZ / 47), 19'(REF_HZ / 62), 19'(REF_HZ / 94)};
   // Spin-up: base step of 0.2 s, code selects a multiple of it
   localparam int SPIN_BASE_MS = 200;
   localparam int SPIN_BASE_DEF = REF_CLK_KHZ * SPIN_BASE_MS;
   localparam logic [5:0] SPIN_MULT [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h0a, 6'h14, 6'h28};
   // Duty constants
   localparam logic [7:0] DUTY_FULL = 8'hff;
   localparam logic [7:0] DUTY_OFF = 8'h00;
   localparam int THRESH_STEP_LOG2 = 2;
   localparam logic [2:0] SLOPE_MAX_CODE = 3'h4;
   localparam int DUTY_FRAC_BITS = 8;

   typedef struct packed {
      logic spin_disable;
      logic reserved;
      logic [2:0] freq_code_sel;
      logic [2:0] spinup_time_sel;
   } fan_cfg_s;

   typedef struct packed {
      logic [4:0] low_thresh;
      logic [2:0] slope_sel;
   } curve_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef enum logic [1:0] {SPIN_IDLE, SPIN_RUN, SPIN_NORMAL} spin_e;
endpackage

// ==== hw/fan_pwm_temp_curve_control.sv ====
// Purpose: Fan PWM generator with automatic temperature-to-duty curve and spin-up.
// Assumes: Temperatures are unsigned whole degrees C, synchronous to sys_clk.
// Notes: Register port is a simple strobed access; read data appears one cycle later.
// Behaviour
// - PWM timing comes from a 3.2 MHz reference derived from the system clock.
// - Range pin low selects high range; high or floating selects low range.
// - Frequency code spans 1-40 kHz or 10-94 Hz, default 25 kHz or 30 Hz.
// - Codes map to 10..94 Hz low range and 1k..40k Hz high range.
// - On fan start, full duty is driven for the selected spin-up time.
// - Spin-up time field is ignored while spin disable is one.
// - Spin disable one suppresses spin-up; zero enables it.
// - Spin-up codes give 0.2 to 8 seconds, code 101 after reset.
// - Low-temperature duty register at 0x21, reset 0x55, used at or below threshold.
// - Local curve register at 0x24 resets to 0x41, holding threshold and slope.
// - Local threshold bits 7:3 in 4 C steps, 0 to 124 C, default 32 C.
// - Local mode duty equals low-temperature duty at or below local threshold.
// - Above threshold duty rises 32,16,8,4,2 LSB per degree by slope code.
// - Remote curve register at 0x25 resets to 0x61, same encodings as local.
// - Remote threshold bits 7:3 in 4 C steps, default 48 C.
// - Remote mode duty equals low-temperature duty at or below remote threshold.
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_temp_curve_control
   import fan_curve_pkg::*;
#(
   parameter logic [18:0] LOW_PERIOD_TICKS [8] = fan_curve_pkg::LOW_PERIOD_DEF,
   parameter int SPIN_BASE_TICKS = fan_curve_pkg::SPIN_BASE_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register access
   input wire fan_curve_pkg::reg_req_s reg_req,
   output logic [7:0] reg_rdata_q,
   // Range pin and control inputs
   input wire logic pwm_range_pin,
   input wire logic temp_src_remote,
   input wire logic [7:0] local_temp,
   input wire logic [7:0] remote_temp,
   // Fan drive and status
   output logic pwm_out_q,
   output logic [7:0] duty_level_q,
   output logic spin_active_q
);
   import fan_curve_pkg::*;

   // Shift amount for a slope code; undefined codes fall to the gentlest slope
   function automatic logic [2:0] slope_shift(input logic [2:0] code);
      if (code > SLOPE_MAX_CODE) begin
         slope_shift = 3'h1;
      end else begin
         slope_shift = 3'h5 - code;
      end
   endfunction

   // Register file
   fan_cfg_s fan_cfg_q, fan_cfg_d;
   logic [7:0] low_temp_duty_value_q, low_temp_duty_value_d;
   curve_s local_curve_q, local_curve_d, remote_curve_q, remote_curve_d;
   logic [7:0] rdata_d;

   always_comb begin
      fan_cfg_d = fan_cfg_q;
      low_temp_duty_value_d = low_temp_duty_value_q;
      local_curve_d = local_curve_q;
      remote_curve_d = remote_curve_q;
      rdata_d = reg_rdata_q;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            FAN_CFG_ADDR: fan_cfg_d = fan_cfg_s'(reg_req.wdata & FAN_CFG_WMASK);
            LOW_TEMP_DUTY_ADDR: low_temp_duty_value_d = reg_req.wdata;
            LOCAL_CURVE_ADDR: local_curve_d = curve_s'(reg_req.wdata);
            REMOTE_CURVE_ADDR: remote_curve_d = curve_s'(reg_req.wdata);
            default: ;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            FAN_CFG_ADDR: rdata_d = fan_cfg_q;
            LOW_TEMP_DUTY_ADDR: rdata_d = low_temp_duty_value_q;
            LOCAL_CURVE_ADDR: rdata_d = local_curve_q;
            REMOTE_CURVE_ADDR: rdata_d = remote_curve_q;
            default: rdata_d = DUTY_OFF; // Unmapped reads as zero
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fan_cfg_q <= fan_cfg_s'(FAN_CFG_RST);
         low_temp_duty_value_q <= LOW_TEMP_DUTY_RST;
         local_curve_q <= curve_s'(LOCAL_CURVE_RST);
         remote_curve_q <= curve_s'(REMOTE_CURVE_RST);
         reg_rdata_q <= DUTY_OFF;
      end else begin
         fan_cfg_q <= fan_cfg_d;
         low_temp_duty_value_q <= low_temp_duty_value_d;
         local_curve_q <= local_curve_d;
         remote_curve_q <= remote_curve_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // Temperature curve; the sum is kept wide so overflow can be caught, not wrapped
   curve_s curve_sel;
   logic [7:0] temp_sel;
   logic [7:0] thresh_c;
   logic [7:0] excess;
   logic [15:0] raised;
   logic [7:0] duty_calc;

   always_comb begin
      curve_sel = temp_src_remote ? remote_curve_q : local_curve_q;
      temp_sel = temp_src_remote ? remote_temp : local_temp;
      thresh_c = {1'b0, curve_sel.low_thresh, 2'b00};
      excess = temp_sel - thresh_c;
      raised = {8'h00, low_temp_duty_value_q} + ({8'h00, excess} << slope_shift(curve_sel.slope_sel));
      if (temp_sel <= thresh_c) begin
         duty_calc = low_temp_duty_value_q;
      end else if (raised > {8'h00, DUTY_FULL}) begin
         duty_calc = DUTY_FULL;
      end else begin
         duty_calc = raised[7:0];
      end
   end

   // Spin-up sequencer: a start is the demand leaving zero, including after reset
   spin_e spin_q, spin_d;
   logic [24:0] spin_cnt_q, spin_cnt_d;
   logic [24:0] spin_limit;
   logic [7:0] duty_d;
   logic ref_tick;

   always_comb begin
      spin_limit = 25'(SPIN_BASE_TICKS * SPIN_MULT[fan_cfg_q.spinup_time_sel]);
      spin_d = spin_q;
      spin_cnt_d = spin_cnt_q;
      duty_d = duty_calc;
      unique case (spin_q)
         SPIN_IDLE: begin
            if (duty_calc != DUTY_OFF) begin
               spin_d = fan_cfg_q.spin_disable ? SPIN_NORMAL : SPIN_RUN;
               spin_cnt_d = '0;
            end
         end
         SPIN_RUN: begin
            if (ref_tick) begin
               spin_cnt_d = spin_cnt_q + 25'h1;
            end
            // A time code shortened mid-run ends the spin at once instead of overrunning
            if (fan_cfg_q.spin_disable || spin_cnt_q >= spin_limit
               || (spin_cnt_q >= spin_limit - 25'h1 && ref_tick)) begin
               spin_d = SPIN_NORMAL;
            end
         end
         SPIN_NORMAL: begin
            if (duty_calc == DUTY_OFF) begin
               spin_d = SPIN_IDLE;
            end
         end
      endcase
      // Full drive follows the next state so duty and the spin flag change together
      if (spin_d == SPIN_RUN) begin
         duty_d = DUTY_FULL;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         spin_q <= SPIN_IDLE;
         spin_cnt_q <= '0;
         duty_level_q <= DUTY_OFF;
         spin_active_q <= 1'b0;
      end else begin
         spin_q <= spin_d;
         spin_cnt_q <= spin_cnt_d;
         duty_level_q <= duty_d;
         spin_active_q <= (spin_d == SPIN_RUN);
      end
   end

   // Reference tick: fractional accumulator, since 250/3.2 is not a whole ratio
   logic [17:0] acc_q, acc_d;
   logic [17:0] acc_sum;

   always_comb begin
      acc_sum = acc_q + ACC_STEP;
      ref_tick = (acc_sum >= ACC_MOD);
      acc_d = ref_tick ? acc_sum - ACC_MOD : acc_sum;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_q <= '0;
      end else begin
         acc_q <= acc_d;
      end
   end

   // PWM period counter; jitter of one system cycle per edge is the cost of the ratio
   logic [18:0] period;
   logic [18:0] pwm_cnt_q, pwm_cnt_d;
   logic [26:0] on_ticks;
   logic pwm_d;

   always_comb begin
      if (pwm_range_pin) begin
         period = LOW_PERIOD_TICKS[fan_cfg_q.freq_code_sel];
      end else begin
         period = 19'(REF_HZ / HIGH_FREQ_HZ[fan_cfg_q.freq_code_sel]);
      end
      on_ticks = 27'(period) * 27'(duty_level_q);
      pwm_cnt_d = pwm_cnt_q;
      if (ref_tick) begin
         pwm_cnt_d = (pwm_cnt_q >= period - 19'h1) ? '0 : pwm_cnt_q + 19'h1;
      end
      if (duty_level_q == DUTY_FULL) begin
         pwm_d = 1'b1; // Full code means fully on
      end else begin
         pwm_d = ({pwm_cnt_q, 8'h00} < on_ticks);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pwm_cnt_q <= '0;
         pwm_out_q <= 1'b0;
      end else begin
         pwm_cnt_q <= pwm_cnt_d;
         pwm_out_q <= pwm_d;
      end
   end

   // Checks
   sequence spin_start_s;
      spin_q == SPIN_IDLE && duty_calc != DUTY_OFF && !fan_cfg_q.spin_disable;
   endsequence
   sequence full_drive_s;
      spin_q == SPIN_RUN && spin_active_q && duty_level_q == DUTY_FULL;
   endsequence

   ref_acc_bound_a: assert property (@(posedge sys_clk) disable iff (rst) acc_q < ACC_MOD)
      else $error("reference accumulator out of range");
   tick_spacing_a: assert property (@(posedge sys_clk) disable iff (rst)
      ref_tick |=> !ref_tick)
      else $error("reference ticks back to back");
   high_range_a: assert property (@(posedge sys_clk) disable iff (rst)
      !pwm_range_pin && fan_cfg_q.freq_code_sel == 3'h3 |-> period == 19'd128)
      else $error("high range period wrong");
   spin_enter_a: assert property (@(posedge sys_clk) disable iff (rst)
      spin_start_s |=> full_drive_s)
      else $error("spin-up not entered with full duty");
   spin_duty_a: assert property (@(posedge sys_clk) disable iff (rst)
      spin_active_q |-> duty_level_q == DUTY_FULL)
      else $error("spin-up without full duty");
   spin_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      fan_cfg_q.spin_disable |=> !spin_active_q)
      else $error("spin-up while disabled");
   spin_len_a: assert property (@(posedge sys_clk) disable iff (rst)
      spin_q == SPIN_RUN && $past(spin_q) == SPIN_RUN && $stable(fan_cfg_q)
      |-> spin_cnt_q < spin_limit)
      else $error("spin-up ran past limit");
   low_duty_a: assert property (@(posedge sys_clk) disable iff (rst)
      spin_q == SPIN_NORMAL && spin_d == SPIN_NORMAL && temp_sel <= thresh_c
      |=> duty_level_q == $past(low_temp_duty_value_q))
      else $error("duty not low-temperature value");
   no_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
      temp_sel > thresh_c |-> duty_calc >= low_temp_duty_value_q)
      else $error("duty wrapped");
   slope_undef_a: assert property (@(posedge sys_clk) disable iff (rst)
      curve_sel.slope_sel > SLOPE_MAX_CODE && temp_sel == thresh_c + 8'h1
      && low_temp_duty_value_q < 8'hfe |-> duty_calc == low_temp_duty_value_q + 8'h2)
      else $error("undefined slope not 2 per degree");
   reset_vals_a: assert property (@(posedge sys_clk)
      rst |=> low_temp_duty_value_q == LOW_TEMP_DUTY_RST && local_curve_q == LOCAL_CURVE_RST
      && remote_curve_q == REMOTE_CURVE_RST)
      else $error("register reset value wrong");
endmodule
`default_nettype wire

// ==== tb/fan_model.sv ====
// Purpose: Behavioural fan that times the drive waveform it receives.
// Assumes: Drive high means on; sampled on the system clock.
// Notes: A real fan only filters this; here we time rise-to-rise periods.
`timescale 1ns/10ps
`default_nettype none
module fan_model (
   // Clock
   input wire logic sys_clk,
   // Drive from the controller
   input wire logic pwm_in,
   // Measurements
   output logic [31:0] period_cyc,
   output int rises
);
   // Start clean so the first period is simply short, never unknown
   logic [31:0] cnt = '0;
   logic last = 1'b0;
   logic [31:0] per_q = '0;
   int rise_cnt = 0;
   assign period_cyc = per_q;
   assign rises = rise_cnt;
   // Time each drive period from one rising edge to the next
   always @(posedge sys_clk) begin
      last <= pwm_in;
      cnt <= cnt + 1;
      if (pwm_in && !last) begin
         per_q <= cnt;
         cnt <= 1;
         rise_cnt <= rise_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/fan_pwm_temp_curve_control_tb.sv ====
// Purpose: Self-checking bench for the fan PWM curve controller.
// Assumes: Inputs change on the falling edge; short counts via parameters.
// Notes: Tick-based times are checked within one reference tick.
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_temp_curve_control_tb;
   import fan_curve_pkg::*;
   localparam int SPIN_T = 2;
   localparam logic [18:0] LOW_T [8] = '{19'h08, 19'h09, 19'h0a, 19'h0b,
      19'h0c, 19'h0d, 19'h0e, 19'h0f};
   int mults [8] = '{1, 2, 3, 4, 5, 10, 20, 40};
   logic [7:0] tl [3] = '{8'h7c, 8'h7d, 8'h84};
   logic [7:0] tr [3] = '{8'h30, 8'h31, 8'h3c};
   logic sys_clk, rst, pwm_range, src_remote, pwm, spin;
   reg_req_s req;
   logic [7:0] rdata, duty, local_t, remote_t;
   logic [31:0] per;
   int rises, fails, samples_checked;

   fan_pwm_temp_curve_control #(.LOW_PERIOD_TICKS(LOW_T), .SPIN_BASE_TICKS(SPIN_T)) DUT (
      .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata_q(rdata),
      .pwm_range_pin(pwm_range), .temp_src_remote(src_remote), .local_temp(local_t),
      .remote_temp(remote_t), .pwm_out_q(pwm), .duty_level_q(duty), .spin_active_q(spin));
   fan_model fan (.sys_clk(sys_clk), .pwm_in(pwm), .period_cyc(per), .rises(rises));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Range compare: an unknown value makes the test false, never true
   task automatic chk_rng(input string what, input int lo, input int hi,
      input logic [31:0] got);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req.wr = 1;
      req.addr = a;
      req.wdata = d;
      @(negedge sys_clk);
      req.wr = 0;
      // One idle edge so back-to-back calls never re-raise a strobe in the same step
      @(negedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      req.rd = 1;
      req.addr = a;
      @(negedge sys_clk);
      req.rd = 0;
      chk("register read", exp, rdata);
      @(negedge sys_clk);
   endtask
   task automatic duty_at(input logic [7:0] lt, input logic [7:0] rt, input logic [7:0] exp);
      local_t = lt;
      remote_t = rt;
      @(negedge sys_clk);
      chk("duty", exp, duty);
   endtask
   // Expected curve worked out from threshold steps and slope table
   function automatic logic [7:0] curve(input logic [7:0] base, input logic [4:0] thr,
      input logic [2:0] s, input logic [7:0] t);
      int lsb [8] = '{32, 16, 8, 4, 2, 2, 2, 2};
      int v;
      v = (t <= thr * 4) ? base : base + (t - thr * 4) * lsb[s];
      return (v > 255) ? 8'hff : 8'(v);
   endfunction
   // Let any running spin finish, stop the fan, then restart it and time full drive
   task automatic spin_run(input logic [2:0] code, input int mult);
      int n;
      n = 0;
      while (spin === 1'b1 && n < 30000) begin
         @(negedge sys_clk);
         n++;
      end
      wr(LOW_TEMP_DUTY_ADDR, 8'h00);
      wr(FAN_CFG_ADDR, {2'b00, 3'h3, code});
      wr(LOW_TEMP_DUTY_ADDR, 8'h55);
      n = 0;
      while (spin !== 1'b1 && n < 4) begin
         @(negedge sys_clk);
         n++;
      end
      chk("spin duty", 8'hff, duty);
      n = 0;
      while (spin === 1'b1 && n < 30000) begin
         @(negedge sys_clk);
         n++;
      end
      chk_rng("spin length", SPIN_T * mult * 78 - 80, SPIN_T * mult * 79 + 2, n);
   endtask
   // First period after a code change may be mixed, so take the second
   task automatic period(input logic range, input logic [2:0] code, input int ticks);
      int r, n;
      pwm_range = range;
      wr(FAN_CFG_ADDR, {2'b10, code, 3'h5});
      r = rises + 2;
      n = 0;
      while (rises < r && n < 30000) begin
         @(negedge sys_clk);
         n++;
      end
      chk_rng("pwm period", ticks * 2500 / 32 - 2, ticks * 2500 / 32 + 2, per);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // 250 MHz system clock
   initial begin
      sys_clk = 0;
      forever #2 sys_clk = ~sys_clk;
   end
   // Watchdog at 100k cycles, a third above the longest expected run
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
   // Main sequence
   initial begin
      rst = 1;
      req = '0;
      pwm_range = 1;
      src_remote = 0;
      local_t = 0;
      remote_t = 0;
      fails = 0;
      samples_checked = 0;
      repeat (4) @(negedge sys_clk);
      rst = 0;
      rd(FAN_CFG_ADDR, {2'b00, 3'h3, 3'h5});
      rd(LOW_TEMP_DUTY_ADDR, 8'h55);
      rd(LOCAL_CURVE_ADDR, {5'h08, 3'h1});
      rd(REMOTE_CURVE_ADDR, {5'h0c, 3'h1});
      rd(8'h22, 8'h00);
      chk("spin after reset", 1'b1, spin);
      for (int c = 0; c < 8; c++) spin_run(3'(c), mults[c]);
      // Disable spin-up with a long time code that must be ignored
      wr(LOW_TEMP_DUTY_ADDR, 8'h00);
      wr(FAN_CFG_ADDR, 8'hff);
      rd(FAN_CFG_ADDR, 8'hbf);
      wr(LOW_TEMP_DUTY_ADDR, 8'h55);
      repeat (3) @(negedge sys_clk);
      chk("spin disabled", 1'b0, spin);
      for (int s = 0; s < 8; s++) begin
         wr(LOCAL_CURVE_ADDR, {5'h1f, 3'(s)});
         foreach (tl[i]) duty_at(tl[i], 8'h00, curve(8'h55, 5'h1f, 3'(s), tl[i]));
      end
      src_remote = 1;
      foreach (tr[i]) duty_at(8'hff, tr[i], curve(8'h55, 5'h0c, 3'h1, tr[i]));
      src_remote = 0;
      wr(LOW_TEMP_DUTY_ADDR, 8'h80);
      duty_at(8'h00, 8'h00, 8'h80);
      for (int c = 0; c < 8; c++) period(1'b1, 3'(c), LOW_T[c]);
      period(1'b0, 3'h3, 3200000 / 25000);
      period(1'b0, 3'h5, 3200000 / 40000);
      period(1'b0, 3'h7, 3200000 / 40000);
      print_verdict();
   end
endmodule
`default_nettype wire
